/* bench/pms_host_model.sv */
// Host controller model: APB master and trigger/done pin driver
`timescale 1ns/1ps

module pms_host_model (
  input  wire logic        core_clk,  // Bench clock
  input  wire logic        pready,    // Slave ready
  output logic             psel,      // Select
  output logic             penable,   // Access phase
  output logic             pwrite,    // Direction
  output logic [11:0]      paddr,     // Byte address
  output logic [31:0]      pwdata,    // Write data
  output logic             trig_evt,  // Trigger event pin
  output logic             meas_done  // Measurement complete pin
);
  // Quiet bus and pins from time zero; address and data wait for the first setup
  initial begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    trig_evt  = 1'b0;
    meas_done = 1'b0;
  end

  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // Rising edge on a pin, held long enough for the two-flop sync
  task automatic pin_pulse(input logic is_trig);
    if (is_trig) begin
      trig_evt <= 1'b1;
    end else begin
      meas_done <= 1'b1;
    end
    repeat (3) @(posedge core_clk);
    trig_evt  <= 1'b0;
    meas_done <= 1'b0;
    // Sync plus edge detect take three cycles; margin added
    repeat (4) @(posedge core_clk);
  endtask
endmodule // pms_host_model

/* bench/pms_sequencer_tb_top.sv */
// Self-checking testbench of the measurement sequencer
`timescale 1ns/1ps
`include "pms_defines.svh"

module pms_sequencer_tb_top;
  import pms_pkg::*;
  logic               core_clk = 1'b0;  // 100 MHz
  logic               rst = 1'b1;       // Sync reset
  logic               psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;            // Byte address
  logic [31:0]        pwdata, prdata;   // Bus data
  logic               trig_evt, meas_done, measuring, result_valid;
  logic [1:0]         active_path;      // Path in use
  logic               auto_path;        // Auto path flag
  logic signed [11:0] path_ofs;         // Transition offset
  pms_func_e          meas_func;        // Mode
  pms_feed_e          result_feed;      // Feed
  logic               aux_min_max, aux_random_samples;
  logic [64:0]        notes[$];         // Read notes: {err, mask, exp}
  logic [64:0]        note;             // Oldest note
  int                 error_cnt = 0;    // Mismatches
  int                 check_count = 0;  // Comparisons
  int                 res_cnt = 0;      // Result pulses seen
  int                 cyc = 0;          // Timeout counter
  int                 seed = 32'h5f72;  // Random seed

  always #5 core_clk = ~core_clk;

  pms_host_model host (.core_clk(core_clk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .trig_evt(trig_evt), .meas_done(meas_done));

  pms_sequencer DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .trig_evt(trig_evt), .meas_done(meas_done), .measuring(measuring), .result_valid(result_valid),
    .active_path(active_path), .auto_path(auto_path), .path_ofs(path_ofs), .meas_func(meas_func),
    .result_feed(result_feed), .aux_min_max(aux_min_max), .aux_random_samples(aux_random_samples));

  // One compare; unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask

  // Read: note goes on the queue, the watcher compares
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
    notes.push_back({er, m, e & m});
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Read watcher: oldest note against the completed read
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = notes.pop_front();
      check({31'h0, pslverr}, {31'h0, note[64]});
      check(prdata & note[63:32], note[31:0]);
    end
  end

  // Result pulses and hang guard
  always @(posedge core_clk) begin
    if (result_valid === 1'b1) res_cnt++;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    logic [11:0] o12, e12;
    logic [1:0]  pth, ep, f, fd, ax, efd, eax;
    logic        au, acc;
    int          sv, r0;
    ep  = 2'h2;
    efd = 2'h0;
    eax = 2'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    rd(`PMS_OFF_PATH, 32'h0000_0012, '1, 1'b0);
    rd(`PMS_OFF_MODE, 32'h0000_0000, '1, 1'b0);
    rd(`PMS_OFF_CTRL, 32'h0000_0000, '1, 1'b0);
    rd(`PMS_OFF_STATUS, 32'h0000_0001, '1, 1'b0);
    rd(`PMS_OFF_TRIGCNT, 32'h0000_0001, '1, 1'b0);
    rd(12'h014, 32'h0000_0000, '1, 1'b1);
    // Random path and offset, boundaries forced first
    for (int i = 0; i < 10; i++) begin
      {au, pth, o12} = 15'($random(seed));
      if (i < 2) o12 = i ? 12'h7FF : 12'h800;
      sv = $signed(o12);
      e12 = (sv < -2000) ? 12'h830 : ((sv > 0) ? 12'h000 : o12);
      if (pth != 2'h3) ep = pth;
      wr(`PMS_OFF_PATH, {12'h0, o12, 3'h0, au, 2'h0, pth});
      repeat (2) @(posedge core_clk);
      check({19'h0, auto_path, path_ofs}, {19'h0, au, e12});
      check({30'h0, active_path}, {30'h0, ep});
      rd(`PMS_OFF_PATH, {12'h0, e12, 3'h0, au, 2'h0, ep}, '1, 1'b0);
    end
    // Every mode, feed and aux code
    for (int k = 0; k < 64; k++) begin
      {f, fd, ax} = k[5:0];
      acc = (f == 2'h3) ? (fd != 2'h0) : (fd != 2'h3);
      if (acc) efd = fd;
      if (ax != 2'h3) eax = ax;
      wr(`PMS_OFF_MODE, {22'h0, ax, 2'h0, fd, 2'h0, f});
      repeat (2) @(posedge core_clk);
      check({30'h0, meas_func}, {30'h0, f});
      check({30'h0, result_feed}, {30'h0, efd});
      check({30'h0, aux_random_samples, aux_min_max}, {30'h0, eax == 2'h2, eax == 2'h1});
      if (!acc) rd(`PMS_OFF_STATUS, 32'h0000_0010, 32'h0000_0010, 1'b0);
    end
    // Feed chosen before any start, continuous off
    wr(`PMS_OFF_MODE, 32'h0000_0000);
    // Single run, one trigger
    r0 = res_cnt;
    wr(`PMS_OFF_CTRL, 32'h0000_0002);
    rd(`PMS_OFF_STATUS, 32'h0000_0002, 32'h0000_00EF, 1'b0);
    host.pin_pulse(1'b1);
    check({31'h0, measuring}, 32'h0000_0001);
    rd(`PMS_OFF_STATUS, 32'h0000_0004, 32'h0000_00EF, 1'b0);
    host.pin_pulse(1'b0);
    check({31'h0, measuring}, 32'h0000_0000);
    rd(`PMS_OFF_STATUS, 32'h0000_0021, 32'h0000_00EF, 1'b0);
    check(res_cnt - r0, 32'h0000_0001);
    // Two triggers per single run, by software strobes
    wr(`PMS_OFF_TRIGCNT, 32'h0000_0002);
    wr(`PMS_OFF_TRIGCNT, 32'h0000_0000);
    rd(`PMS_OFF_TRIGCNT, 32'h0000_0002, '1, 1'b0);
    r0 = res_cnt;
    wr(`PMS_OFF_CTRL, 32'h0000_0002);
    wr(`PMS_OFF_CTRL, 32'h0000_0008);
    wr(`PMS_OFF_CTRL, 32'h0000_0010);
    rd(`PMS_OFF_STATUS, 32'h0000_0102, 32'h0000_FFEF, 1'b0);
    check(res_cnt - r0, 32'h0000_0000);
    wr(`PMS_OFF_CTRL, 32'h0000_0008);
    wr(`PMS_OFF_CTRL, 32'h0000_0010);
    rd(`PMS_OFF_STATUS, 32'h0000_0021, 32'h0000_00EF, 1'b0);
    check(res_cnt - r0, 32'h0000_0001);
    wr(`PMS_OFF_TRIGCNT, 32'h0000_0001);
    // Abort in mid-measurement of a single run
    r0 = res_cnt;
    wr(`PMS_OFF_CTRL, 32'h0000_0002);
    host.pin_pulse(1'b1);
    wr(`PMS_OFF_CTRL, 32'h0000_0004);
    rd(`PMS_OFF_STATUS, 32'h0000_0001, 32'h0000_00EF, 1'b0);
    check({31'h0, measuring}, 32'h0000_0000);
    // Continuous: rearm, abort, stop
    wr(`PMS_OFF_CTRL, 32'h0000_0001);
    rd(`PMS_OFF_STATUS, 32'h0000_000A, 32'h0000_00CF, 1'b0);
    host.pin_pulse(1'b1);
    host.pin_pulse(1'b0);
    rd(`PMS_OFF_STATUS, 32'h0000_000A, 32'h0000_00CF, 1'b0);
    check(res_cnt - r0, 32'h0000_0001);
    host.pin_pulse(1'b1);
    wr(`PMS_OFF_CTRL, 32'h0000_0005);
    rd(`PMS_OFF_STATUS, 32'h0000_000A, 32'h0000_00CF, 1'b0);
    host.pin_pulse(1'b1);
    rd(`PMS_OFF_STATUS, 32'h0000_000C, 32'h0000_00CF, 1'b0);
    wr(`PMS_OFF_CTRL, 32'h0000_0000);
    rd(`PMS_OFF_STATUS, 32'h0000_0001, 32'h0000_00CF, 1'b0);
    rd(`PMS_OFF_CTRL, 32'h0000_0000, '1, 1'b0);
    repeat (2) @(posedge core_clk);
    conclude();
  end
endmodule // pms_sequencer_tb_top

/* hdl/pms_sequencer.sv */
// Measurement-control sequencer: path, mode, feed, aux settings and trigger state machine
//
// Function
// RULE_01 - Active path 0..2, reset to 2
// RULE_02 - Auto path selection, on after reset
// RULE_03 - Transition offset -20..0 dB, lowers both transitions
// RULE_04 - Four measurement modes, continuous average default
// RULE_05 - Scalar modes feed average, peak or random
// RULE_06 - Trace mode feed trace, peak or random
// RULE_07 - Host sets feed before start; default average
// RULE_08 - Aux modes none, aux_min_max, random; default none
// RULE_09 - Aux_min_max aux delivers trace min and max
// RULE_10 - Random aux replaces averages in evaluations
// RULE_11 - Abort stops; single run goes idle
// RULE_12 - Abort in continuous goes to wait
// RULE_13 - Single start moves idle to wait
// RULE_14 - Multi-trigger single returns wait, finally idle
// RULE_15 - Host starts single only with continuous off
// RULE_16 - Continuous returns to wait after each measurement
// RULE_17 - Continuous off goes idle; off after reset
// RULE_18 - Idle after power-on
// RULE_19 - Trigger event moves wait to measuring
// RULE_20 - Measuring until completion, then leave at once
// RULE_21 - Trigger count one gives one result
// RULE_22 - Feed not fitting mode is rejected
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "pms_defines.svh"

module pms_sequencer (
  input  wire logic             core_clk,          // 100 MHz clock
  input  wire logic             rst,               // Synchronous reset, active high
  input  wire logic             psel,              // APB select
  input  wire logic             penable,           // APB enable
  input  wire logic             pwrite,            // APB direction
  input  wire logic [11:0]      paddr,             // APB byte address
  input  wire logic [31:0]      pwdata,            // APB write data
  output logic                  pready,            // APB ready
  output logic [31:0]           prdata,            // APB read data
  output logic                  pslverr,           // APB error on unmapped address
  input  wire logic             trig_evt,          // Trigger event pin, asynchronous
  input  wire logic             meas_done,         // Measurement complete pin, asynchronous
  output logic                  measuring,         // In measuring state
  output logic                  result_valid,      // One-cycle pulse: cycle result ready
  output logic [1:0]            active_path,       // Path in use
  output logic                  auto_path,         // Automatic path selection on
  output logic signed [11:0]    path_ofs,          // Transition offset, 0.01 dB steps
  output pms_pkg::pms_func_e    meas_func,         // Measurement mode
  output pms_pkg::pms_feed_e    result_feed,       // Result feed
  output logic                  aux_min_max,       // Deliver min/max with each result
  output logic                  aux_random_samples // Use random samples for evaluation
);
  import pms_pkg::*;

  // Settings
  logic [1:0]             path_q;        // Active path
  logic                   auto_q;        // Auto path selection
  logic signed [11:0]     ofs_q;         // Transition offset
  pms_func_e              func_q;        // Mode
  pms_feed_e              feed_q;        // Feed
  pms_aux_e               aux_q;         // Aux mode
  logic                   cont_q;        // Continuous mode
  logic [7:0]             tcount_q;      // Trigger events per single cycle
  logic                   rej_q;         // Sticky: last feed write refused
  logic                   res_q;         // Sticky: a result was produced
  // Trigger machine
  pms_state_e             state_q;       // Trigger state
  logic [7:0]             done_cnt_q;    // Partial measurements done this cycle
  // Pin synchronisers
  logic [1:0]             trig_sync_q;   // Trigger pin sync
  logic [1:0]             done_sync_q;   // Done pin sync
  logic                   trig_prev_q;   // Edge detect after sync
  logic                   done_prev_q;   // Edge detect after sync
  // Bus decode
  logic                   wr_en;         // Write accepted this cycle
  logic                   acc;           // Access phase
  logic                   hit;           // Address mapped
  logic                   sw_init;       // Single-start command
  logic                   sw_abort;      // Abort command
  logic                   sw_trig;       // Software trigger
  logic                   sw_done;       // Software completion
  logic                   cont_off;      // Continuous being switched off
  logic                   trig_hit;      // Any trigger event
  logic                   done_hit;      // Any completion
  logic                   last_part;     // Completion ends the single cycle
  pms_feed_e              feed_w;        // Feed field of a write
  pms_func_e              func_w;        // Mode field of a write
  logic signed [11:0]     ofs_w;         // Offset field of a write
  logic                   feed_ok;       // Feed suits the new mode

  // Two-flop synchronisers; only the second stage is read further on
  // Edge detectors reset low, matching the idle level of both pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_sync_q <= 2'h0;
      done_sync_q <= 2'h0;
      trig_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[0], trig_evt};
      done_sync_q <= {done_sync_q[0], meas_done};
      trig_prev_q <= trig_sync_q[1];
      done_prev_q <= done_sync_q[1];
    end
  end

  // Bus decode; every access completes with no wait state
  assign acc     = psel && penable;
  assign hit     = (paddr == `PMS_OFF_PATH) || (paddr == `PMS_OFF_MODE) || (paddr == `PMS_OFF_CTRL) ||
                   (paddr == `PMS_OFF_STATUS) || (paddr == `PMS_OFF_TRIGCNT);
  assign wr_en   = acc && pwrite && hit;
  assign sw_init  = wr_en && (paddr == `PMS_OFF_CTRL) && pwdata[`PMS_INIT_BIT];
  assign sw_abort = wr_en && (paddr == `PMS_OFF_CTRL) && pwdata[`PMS_ABORT_BIT];
  assign sw_trig  = wr_en && (paddr == `PMS_OFF_CTRL) && pwdata[`PMS_TRIG_BIT];
  assign sw_done  = wr_en && (paddr == `PMS_OFF_CTRL) && pwdata[`PMS_DONE_BIT];
  assign cont_off = wr_en && (paddr == `PMS_OFF_CTRL) && !pwdata[`PMS_CONT_BIT] && cont_q;
  assign trig_hit = sw_trig || (trig_sync_q[1] && !trig_prev_q);
  assign done_hit = sw_done || (done_sync_q[1] && !done_prev_q);
  assign last_part = (done_cnt_q + 8'h01) >= tcount_q;
  assign feed_w   = pms_feed_e'(pwdata[`PMS_FEED_HI:`PMS_FEED_LO]);
  assign func_w   = pms_func_e'(pwdata[`PMS_FUNC_HI:`PMS_FUNC_LO]);
  assign ofs_w    = $signed(pwdata[`PMS_OFS_HI:`PMS_OFS_LO]);

  // Feed validity against the mode being written
  always_comb begin
    if (func_w == PMS_TRACE) begin
      feed_ok = (feed_w != PMS_FEED_AVG);   // Trace, peak or random per point; see RULE_06
    end else begin
      feed_ok = (feed_w != PMS_FEED_TRACE); // Average, peak or random; see RULE_05
    end
  end

  // APB answer: single-cycle access, error on unmapped address
  // No wait states: pready rises in the cycle after any setup phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // Path settings; an out-of-range path is ignored, keeping the old one; the offset is clamped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      path_q <= `PMS_PATH_RST;                       // see RULE_01
      auto_q <= 1'b1;                                // see RULE_02
      ofs_q  <= `PMS_OFS_RST;                        // see RULE_03
    end else if (wr_en && paddr == `PMS_OFF_PATH) begin
      if (pwdata[`PMS_PATH_SEL_HI:`PMS_PATH_SEL_LO] <= `PMS_PATH_MAX) begin
        path_q <= pwdata[`PMS_PATH_SEL_HI:`PMS_PATH_SEL_LO]; // see RULE_01
      end
      auto_q <= pwdata[`PMS_PATH_AUTO_BIT];          // see RULE_02
      // Clamp outside range; offset only lowers transitions
      if (ofs_w < `PMS_OFS_MIN) begin
        ofs_q <= `PMS_OFS_MIN;                       // see RULE_03
      end else if (ofs_w > `PMS_OFS_MAX) begin
        ofs_q <= `PMS_OFS_MAX;
      end else begin
        ofs_q <= ofs_w;
      end
    end
  end

  // Mode, feed, aux; a feed unsuited to the mode is refused
  always_ff @(posedge core_clk) begin
    if (rst) begin
      func_q <= PMS_CONT_AVG;                        // see RULE_04
      feed_q <= PMS_FEED_AVG;                        // see RULE_07
      aux_q  <= PMS_AUX_NONE;                        // see RULE_08
      rej_q  <= 1'b0;
    end else if (wr_en && paddr == `PMS_OFF_MODE) begin
      func_q <= func_w;                              // see RULE_04
      if (pwdata[`PMS_AUX_HI:`PMS_AUX_LO] != 2'h3) begin
        aux_q <= pms_aux_e'(pwdata[`PMS_AUX_HI:`PMS_AUX_LO]); // see RULE_08
      end
      if (feed_ok) begin
        feed_q <= feed_w;                            // see RULE_05
        rej_q  <= 1'b0;
      end else begin
        // Old feed kept; the sticky flag tells software the write was refused
        rej_q <= 1'b1;                               // see RULE_22
      end
    end
  end

  // Continuous mode and trigger count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cont_q   <= 1'b0;                              // see RULE_17
      tcount_q <= `PMS_TRIGCNT_RST;
    end else if (wr_en) begin
      if (paddr == `PMS_OFF_CTRL) begin
        cont_q <= pwdata[`PMS_CONT_BIT];
      end
      if (paddr == `PMS_OFF_TRIGCNT && pwdata[`PMS_TRIGCNT_W-1:0] != 8'h00) begin
        tcount_q <= pwdata[`PMS_TRIGCNT_W-1:0];
      end
    end
  end

  // Trigger state machine; abort and continuous-off take priority
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q    <= PMS_IDLE;                        // see RULE_18
      done_cnt_q <= 8'h00;
    end else if (cont_off) begin
      state_q    <= PMS_IDLE;                        // see RULE_17
      done_cnt_q <= 8'h00;
    end else if (sw_abort) begin
      state_q    <= cont_q ? PMS_WAIT : PMS_IDLE;    // see RULE_11 see RULE_12
      done_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        PMS_IDLE: begin
          // Host keeps continuous off before a single start
          if (sw_init || (wr_en && paddr == `PMS_OFF_CTRL && pwdata[`PMS_CONT_BIT])) begin
            state_q <= PMS_WAIT;                     // see RULE_13 see RULE_15
          end
          done_cnt_q <= 8'h00;
        end
        PMS_WAIT: begin
          // Pin edge or software strobe, whichever comes first
          if (trig_hit) begin
            state_q <= PMS_MEASURE;                  // see RULE_19
          end
        end
        PMS_MEASURE: begin
          // Completion by pin edge or software strobe
          if (done_hit) begin                        // see RULE_20
            if (cont_q) begin
              state_q    <= PMS_WAIT;                // see RULE_16
              done_cnt_q <= 8'h00;
            end else if (last_part) begin
              state_q    <= PMS_IDLE;                // see RULE_14 see RULE_21
              done_cnt_q <= 8'h00;
            end else begin
              state_q    <= PMS_WAIT;                // see RULE_14
              done_cnt_q <= done_cnt_q + 8'h01;
            end
          end
        end
        default: begin
          // Codes other than the three one-hot states recover to idle
          state_q <= PMS_IDLE;
        end
      endcase
    end
  end

  // Result pulse: each continuous measurement, or end of a single cycle
  // A result in the same cycle as a start wins the sticky flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_valid <= 1'b0;
      res_q        <= 1'b0;
    end else begin
      result_valid <= (state_q == PMS_MEASURE) && done_hit && !sw_abort && !cont_off &&
                      (cont_q || last_part);         // see RULE_21
      if ((state_q == PMS_MEASURE) && done_hit && !sw_abort && !cont_off && (cont_q || last_part)) begin
        res_q <= 1'b1;
      end else if (sw_init) begin
        res_q <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      measuring          <= 1'b0;
      active_path        <= `PMS_PATH_RST;
      auto_path          <= 1'b1;
      path_ofs           <= `PMS_OFS_RST;
      meas_func          <= PMS_CONT_AVG;
      result_feed        <= PMS_FEED_AVG;
      aux_min_max        <= 1'b0;
      aux_random_samples <= 1'b0;
    end else begin
      measuring          <= (state_q == PMS_MEASURE);
      active_path        <= path_q;
      auto_path          <= auto_q;
      path_ofs           <= ofs_q;
      meas_func          <= func_q;
      result_feed        <= feed_q;
      aux_min_max        <= (aux_q == PMS_AUX_AUX_MIN_MAX);  // see RULE_09
      aux_random_samples <= (aux_q == PMS_AUX_RANDOM);  // see RULE_10
    end
  end

  // Read data, captured in setup phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PMS_OFF_PATH:    prdata <= {12'h000, 12'(ofs_q), 3'h0, auto_q, 2'h0, path_q};
        `PMS_OFF_MODE:    prdata <= {22'h00_0000, aux_q, 2'h0, feed_q, 2'h0, func_q};
        `PMS_OFF_CTRL:    prdata <= {31'h0000_0000, cont_q};
        `PMS_OFF_STATUS:  prdata <= {16'h0000, done_cnt_q, 2'h0, res_q, rej_q, cont_q, state_q};
        `PMS_OFF_TRIGCNT: prdata <= {24'h00_0000, tcount_q};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks; all on core_clk, all but a_idle_reset quiet during reset

  // Reset always lands in idle
  a_idle_reset: assert property (@(posedge core_clk) $past(rst) |-> state_q == PMS_IDLE) // see RULE_18
    else $error("not idle after reset");

  // Refused path codes never reach the register
  a_path_range: assert property (@(posedge core_clk) disable iff (rst) path_q <= `PMS_PATH_MAX) // see RULE_01
    else $error("path out of range");

  // Clamp keeps the offset in its span
  a_ofs_range: assert property (@(posedge core_clk) disable iff (rst) // see RULE_03
    ofs_q >= `PMS_OFS_MIN && ofs_q <= `PMS_OFS_MAX)
    else $error("offset out of range");

  // Abort of a single run idles
  a_abort_single: assert property (@(posedge core_clk) disable iff (rst) // see RULE_11
    sw_abort && !cont_q |=> state_q == PMS_IDLE)
    else $error("abort single not idle");

  // Abort while continuous rearms
  a_abort_cont: assert property (@(posedge core_clk) disable iff (rst) // see RULE_12
    sw_abort && cont_q && !cont_off |=> state_q == PMS_WAIT)
    else $error("abort continuous not waiting");

  // Single start arms the trigger
  a_init_wait: assert property (@(posedge core_clk) disable iff (rst) // see RULE_13
    state_q == PMS_IDLE && sw_init && !sw_abort |=> state_q == PMS_WAIT)
    else $error("start did not wait");

  // Trigger starts measuring; the level follows a cycle later
  a_trig_meas: assert property (@(posedge core_clk) disable iff (rst) // see RULE_19
    state_q == PMS_WAIT && trig_hit && !sw_abort && !cont_off |=> state_q == PMS_MEASURE ##1 measuring)
    else $error("trigger not taken");

  // Continuous completion rearms and reports
  a_cont_loop: assert property (@(posedge core_clk) disable iff (rst) // see RULE_16
    state_q == PMS_MEASURE && done_hit && cont_q && !sw_abort && !cont_off |=> state_q == PMS_WAIT ##0 result_valid)
    else $error("continuous did not rearm");

  // Partial completion rearms without a result
  a_part_wait: assert property (@(posedge core_clk) disable iff (rst) // see RULE_14
    state_q == PMS_MEASURE && done_hit && !cont_q && !last_part && !sw_abort |=>
    state_q == PMS_WAIT && !result_valid)
    else $error("partial completion not rearmed");

  // Last completion of a single run reports and idles
  a_single_end: assert property (@(posedge core_clk) disable iff (rst) // see RULE_21
    state_q == PMS_MEASURE && done_hit && !cont_q && last_part && !sw_abort |=>
    state_q == PMS_IDLE && result_valid)
    else $error("single run did not end");

  // Switching continuous off idles at once
  a_cont_off: assert property (@(posedge core_clk) disable iff (rst) cont_off |=> state_q == PMS_IDLE) // see RULE_17
    else $error("continuous off not idle");

  // Refused feed keeps the old one and flags it
  a_feed_legal: assert property (@(posedge core_clk) disable iff (rst) // see RULE_22
    wr_en && paddr == `PMS_OFF_MODE && !feed_ok |=> feed_q == $past(feed_q) && rej_q)
    else $error("bad feed accepted");

  // Main scenarios
  c_single: cover property (@(posedge core_clk) disable iff (rst) sw_init ##[1:20] result_valid);
  c_cont: cover property (@(posedge core_clk) disable iff (rst) cont_q && result_valid);
  c_abort: cover property (@(posedge core_clk) disable iff (rst) state_q == PMS_MEASURE && sw_abort);
  c_partial: cover property (@(posedge core_clk) disable iff (rst) state_q == PMS_WAIT && done_cnt_q != 8'h00);
  c_reject: cover property (@(posedge core_clk) disable iff (rst) wr_en && paddr == `PMS_OFF_MODE && !feed_ok);
endmodule // pms_sequencer

/* inc/pms_defines.svh */
// Register offsets, field layouts, reset values and encodings of the measurement sequencer
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH
// Register byte offsets
`define PMS_OFF_PATH      12'h000
`define PMS_OFF_MODE      12'h004
`define PMS_OFF_CTRL      12'h008
`define PMS_OFF_STATUS    12'h00C
`define PMS_OFF_TRIGCNT   12'h010
// Path register fields
`define PMS_PATH_SEL_LO   0
`define PMS_PATH_SEL_HI   1
`define PMS_PATH_AUTO_BIT 4
`define PMS_OFS_LO        8
`define PMS_OFS_HI        19
// Mode register fields
`define PMS_FUNC_LO       0
`define PMS_FUNC_HI       1
`define PMS_FEED_LO       4
`define PMS_FEED_HI       5
`define PMS_AUX_LO        8
`define PMS_AUX_HI        9
// Control register command bits
`define PMS_CONT_BIT      0
`define PMS_INIT_BIT      1
`define PMS_ABORT_BIT     2
`define PMS_TRIG_BIT      3
`define PMS_DONE_BIT      4
// Status register fields
`define PMS_ST_LO         0
`define PMS_ST_HI         2
`define PMS_ST_CONT_BIT   3
`define PMS_ST_REJ_BIT    4
`define PMS_ST_RES_BIT    5
`define PMS_ST_TC_LO      8
`define PMS_ST_TC_HI      15
// Reset values and limits
`define PMS_PATH_RST      2'h2
`define PMS_PATH_MAX      2'h2
`define PMS_OFS_RST       12'sh000
`define PMS_OFS_MIN       12'sh830
`define PMS_OFS_MAX       12'sh000
`define PMS_TRIGCNT_RST   8'h01
`define PMS_TRIGCNT_W     8
`endif

/* inc/pms_pkg.sv */
// Types of the measurement sequencer
package pms_pkg;
  // Measurement mode
  typedef enum logic [1:0] {
    PMS_CONT_AVG  = 2'h0,
    PMS_BURST_AVG = 2'h1,
    PMS_TIMESLOT  = 2'h2,
    PMS_TRACE     = 2'h3
  } pms_func_e;
  // Result feed; same codes serve scalar and trace flavours
  typedef enum logic [1:0] {
    PMS_FEED_AVG    = 2'h0,
    PMS_FEED_PEAK   = 2'h1,
    PMS_FEED_RANDOM = 2'h2,
    PMS_FEED_TRACE  = 2'h3
  } pms_feed_e;
  // Aux_value_mode value mode
  typedef enum logic [1:0] {
    PMS_AUX_NONE   = 2'h0,
    PMS_AUX_AUX_MIN_MAX = 2'h1,
    PMS_AUX_RANDOM = 2'h2
  } pms_aux_e;
  // Trigger state, one-hot
  typedef enum logic [2:0] {
    PMS_IDLE    = 3'b001,
    PMS_WAIT    = 3'b010,
    PMS_MEASURE = 3'b100
  } pms_state_e;
endpackage
